/* File: core/adcr_pkg.sv */
// Purpose: Shared constants and types for the converter result, compare and configuration registers
// Assumes: APB slave with 32-bit data, one aligned word per byte-wide register
// Notes:   Reset value of every register is zero
`default_nettype none

package adcr_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Widths
   localparam int unsigned BYTE_W   = 8;             // Register width
   localparam int unsigned RESULT_W = 12;            // Full result width
   localparam int unsigned PIN_N    = 8;             // Channel pins governed

   ////////////////////////////////////////////////////////////////////////
   // Register byte addresses
   localparam logic [7:0] OFS_RESULT_HIGH = 8'h00;   // Result high byte, read only
   localparam logic [7:0] OFS_RESULT_LOW  = 8'h04;   // Result low byte, read only
   localparam logic [7:0] OFS_CMP_HIGH    = 8'h08;   // Compare value high byte
   localparam logic [7:0] OFS_CMP_LOW     = 8'h0C;   // Compare value low byte
   localparam logic [7:0] OFS_CONFIG      = 8'h10;   // Converter configuration
   localparam logic [7:0] OFS_PIN_SEL     = 8'h14;   // Analog pin select, channels 0-7
   localparam logic [7:0] OFS_CMP_CTRL    = 8'h18;   // Compare enable and direction
   localparam logic [7:0] OFS_STATUS      = 8'h1C;   // Result valid and interlock state

   ////////////////////////////////////////////////////////////////////////
   // Field positions in the compare control and status words
   localparam int unsigned CMP_EN_BIT    = 0;        // Compare enable
   localparam int unsigned CMP_GT_BIT    = 1;        // Greater-or-equal select
   localparam int unsigned STAT_VAL_BIT  = 0;        // Result valid
   localparam int unsigned STAT_LOCK_BIT = 1;        // Transfer blocked

   ////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [7:0] CFG_RESET = 8'h00;         // High speed, div 1, bus clock, 8-bit
   localparam logic [7:0] CMP_RESET = 8'h00;         // Compare value
   localparam logic [7:0] PIN_RESET = 8'h00;         // All pins under port control

   ////////////////////////////////////////////////////////////////////////
   // Modes and clock choices
   typedef enum logic [1:0] {
      ADCR_MODE_8    = 2'b00,
      ADCR_MODE_12   = 2'b01,
      ADCR_MODE_10   = 2'b10,
      ADCR_MODE_RSVD = 2'b11
   } adcr_mode_t;

   typedef enum logic [1:0] {
      ADCR_SRC_BUS      = 2'b00,
      ADCR_SRC_BUS_HALF = 2'b01,
      ADCR_SRC_ALT      = 2'b10,
      ADCR_SRC_ASYNC    = 2'b11
   } adcr_clk_src_t;

   localparam logic [1:0] DIV_BY_1 = 2'b00;          // Divide codes
   localparam logic [1:0] DIV_BY_8 = 2'b11;

   // Configuration byte, most significant field first
   typedef struct packed {
      logic          low_power;                      // 1 = low power configuration
      logic [1:0]    clock_divide;                   // Divide select
      logic          long_sample;                    // 1 = long sample time
      adcr_mode_t    mode;                           // Resolution
      adcr_clk_src_t input_clock;                    // Clock source
   } adcr_cfg_t;

endpackage

`default_nettype wire

/* File: core/adcr_result_regs.sv */
// Purpose: Result, compare, configuration and pin-select registers of a successive-approximation converter
// Assumes: Conversion core toggles CONV_DONE once per completion and holds CONV_RESULT stable around it
// Notes:   Alternate and async clocks arrive as slow levels and become tick enables here
`default_nettype none

module adcr_result_regs
   import adcr_pkg::*;
(
   input  wire logic            CLK_SYS,
   input  wire logic            RESET_N,
   input  wire logic            PSEL,
   input  wire logic            PENABLE,
   input  wire logic            PWRITE,
   input  wire logic [7:0]      PADDR,
   input  wire logic [31:0]     PWDATA,
   output logic      [31:0]     PRDATA,
   output logic                 PREADY,
   output logic                 PSLVERR,
   input  wire logic            CONV_DONE,
   input  wire logic [11:0]     CONV_RESULT,
   input  wire logic            ALT_CLK,
   input  wire logic            ASYNC_CLK,
   output adcr_cfg_t            CONFIG,
   output logic                 CONV_CLK_EN,
   output logic [PIN_N-1:0]     PIN_IO_DISABLE
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [2:0]           sync_in;        // Inputs from other domains
   logic [2:0]           sync_1;         // First stage
   logic [2:0]           sync_2;         // Second stage
   logic [2:0]           sync_3;         // Third stage
   logic [2:0]           sync_lvl;       // Accepted level
   logic [2:0]           next_sync_lvl;
   logic [2:0]           sync_chg;       // Accepted change, one cycle
   logic                 done_ev;        // Conversion completed
   logic                 alt_tick;       // Alternate clock rising
   logic                 async_tick;     // Async clock rising
   logic                 wr_en;          // Write access phase
   logic                 rd_en;          // Read access phase
   logic                 mapped;         // Address decodes
   logic [BYTE_W-1:0]    wbyte;          // Written byte
   logic [BYTE_W-1:0]    cmp_high;       // Compare value high
   logic [BYTE_W-1:0]    cmp_low;        // Compare value low
   adcr_cfg_t            cfg;            // Configuration
   logic [PIN_N-1:0]     pin_sel;        // Pin select
   logic                 cmp_en;         // Compare enable
   logic                 cmp_gt;         // Greater-or-equal select
   logic [BYTE_W-1:0]    next_cmp_high;
   logic [BYTE_W-1:0]    next_cmp_low;
   adcr_cfg_t            next_cfg;
   logic [PIN_N-1:0]     next_pin_sel;
   logic                 next_cmp_en;
   logic                 next_cmp_gt;
   logic [RESULT_W-1:0]  result;         // Stored result
   logic                 valid;          // Stored result is valid
   logic                 lock;           // Transfers blocked
   logic [RESULT_W-1:0]  next_result;
   logic                 next_valid;
   logic                 next_lock;
   logic [RESULT_W-1:0]  res_m;          // Result masked to mode
   logic [RESULT_W-1:0]  cv;             // Compare value for mode
   logic                 cond;           // Compare condition met
   logic                 interlock_mode; // 12- or 10-bit
   logic                 mode_change;    // Write alters resolution
   logic                 hi_setup;       // High byte read under way
   logic                 store;          // Take new result
   logic [31:0]          rdata;          // Read mux
   logic [31:0]          next_prdata;
   logic                 half;           // Bus clock halving flop
   logic                 src_tick;       // Selected source tick
   logic [2:0]           div_cnt;        // Divider count
   logic [2:0]           div_max;        // Terminal count
   logic                 next_half;
   logic [2:0]           next_div_cnt;
   logic                 next_clk_en;

   ////////////////////////////////////////////////////////////////////////
   // Three-stage synchronisers; a change counts once stages two and three agree
   assign sync_in = {ASYNC_CLK, ALT_CLK, CONV_DONE};

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_sync
         // Accept the agreed level
         always_comb
         begin
            next_sync_lvl[gi] = sync_lvl[gi];
            if (sync_2[gi] == sync_3[gi])
               next_sync_lvl[gi] = sync_3[gi];
         end
         assign sync_chg[gi] = (sync_2[gi] == sync_3[gi]) && (sync_3[gi] != sync_lvl[gi]);
         // Register the chain
         always_ff @(posedge CLK_SYS or negedge RESET_N)
         begin
            if (!RESET_N)
            begin
               sync_1[gi]   <= 1'b0;
               sync_2[gi]   <= 1'b0;
               sync_3[gi]   <= 1'b0;
               sync_lvl[gi] <= 1'b0;
            end
            else
            begin
               sync_1[gi]   <= sync_in[gi];
               sync_2[gi]   <= sync_1[gi];
               sync_3[gi]   <= sync_2[gi];
               sync_lvl[gi] <= next_sync_lvl[gi];
            end
         end
      end
   endgenerate

   assign done_ev    = sync_chg[0];                  // Either edge of the toggle
   assign alt_tick   = sync_chg[1] && sync_3[1];     // Rising edges only
   assign async_tick = sync_chg[2] && sync_3[2];

   ////////////////////////////////////////////////////////////////////////
   // APB decode; zero wait states, unmapped access answers with an error
   assign wr_en   = PSEL && PENABLE && PWRITE;
   assign rd_en   = PSEL && PENABLE && !PWRITE;
   assign wbyte   = PWDATA[BYTE_W-1:0];
   assign mapped  = (PADDR == OFS_RESULT_HIGH) || (PADDR == OFS_RESULT_LOW) || (PADDR == OFS_CMP_HIGH) ||
                    (PADDR == OFS_CMP_LOW) || (PADDR == OFS_CONFIG) || (PADDR == OFS_PIN_SEL) ||
                    (PADDR == OFS_CMP_CTRL) || (PADDR == OFS_STATUS);
   assign PREADY  = 1'b1;
   assign PSLVERR = PSEL && PENABLE && !mapped;

   ////////////////////////////////////////////////////////////////////////
   // Software-written registers
   always_comb
   begin
      next_cmp_high = cmp_high;
      next_cmp_low  = cmp_low;
      next_cfg      = cfg;
      next_pin_sel  = pin_sel;
      next_cmp_en   = cmp_en;
      next_cmp_gt   = cmp_gt;
      if (wr_en)
      begin
         case (PADDR)
            OFS_CMP_HIGH: next_cmp_high = wbyte;
            OFS_CMP_LOW:  next_cmp_low  = wbyte;
            OFS_CONFIG:   next_cfg      = adcr_cfg_t'(wbyte);
            OFS_PIN_SEL:  next_pin_sel  = wbyte;
            OFS_CMP_CTRL:
            begin
               next_cmp_en = wbyte[CMP_EN_BIT];
               next_cmp_gt = wbyte[CMP_GT_BIT];
            end
            default:      next_cmp_en   = cmp_en;              // Result writes fall here
         endcase
      end
   end

   // Register them
   always_ff @(posedge CLK_SYS or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         cmp_high <= CMP_RESET;
         cmp_low  <= CMP_RESET;
         cfg      <= adcr_cfg_t'(CFG_RESET);
         pin_sel  <= PIN_RESET;
         cmp_en   <= 1'b0;
         cmp_gt   <= 1'b0;
      end
      else
      begin
         cmp_high <= next_cmp_high;
         cmp_low  <= next_cmp_low;
         cfg      <= next_cfg;
         pin_sel  <= next_pin_sel;
         cmp_en   <= next_cmp_en;
         cmp_gt   <= next_cmp_gt;
      end
   end

   assign CONFIG         = cfg;
   assign PIN_IO_DISABLE = pin_sel;

   ////////////////////////////////////////////////////////////////////////
   // Result formatting and automatic compare per resolution
   always_comb
   begin
      case (cfg.mode)
         ADCR_MODE_12:
         begin
            res_m = CONV_RESULT;
            cv    = {cmp_high[3:0], cmp_low};
         end
         ADCR_MODE_10:
         begin
            res_m = {2'b00, CONV_RESULT[9:0]};
            cv    = {2'b00, cmp_high[1:0], cmp_low};
         end
         default:
         begin
            res_m = {4'h0, CONV_RESULT[BYTE_W-1:0]};
            cv    = {4'h0, cmp_low};
         end
      endcase
      cond = cmp_gt ? (res_m >= cv) : (res_m < cv);
   end

   assign interlock_mode = (cfg.mode == ADCR_MODE_12) || (cfg.mode == ADCR_MODE_10);
   assign mode_change    = wr_en && (PADDR == OFS_CONFIG) && (next_cfg.mode != cfg.mode);
   // In 12- and 10-bit modes a high byte read holds transfers from its setup cycle on, so both bytes match
   assign hi_setup       = PSEL && !PWRITE && (PADDR == OFS_RESULT_HIGH) && interlock_mode;
   assign store          = done_ev && !lock && !hi_setup && (!cmp_en || cond);

   ////////////////////////////////////////////////////////////////////////
   // Result, valid flag and interlock
   always_comb
   begin
      next_result = result;
      next_valid  = valid;
      next_lock   = lock;
      if (mode_change)
      begin
         // Mode change wins over a completing conversion
         next_result = '0;
         next_valid  = 1'b0;
         next_lock   = 1'b0;
      end
      else
      begin
         if (store)
         begin
            next_result = res_m;
            next_valid  = 1'b1;
         end
         if (rd_en && (PADDR == OFS_RESULT_HIGH) && interlock_mode)
            next_lock = 1'b1;
         else if (rd_en && (PADDR == OFS_RESULT_LOW))
            next_lock = 1'b0;
      end
   end

   // Register them
   always_ff @(posedge CLK_SYS or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         result <= '0;
         valid  <= 1'b0;
         lock   <= 1'b0;
      end
      else
      begin
         result <= next_result;
         valid  <= next_valid;
         lock   <= next_lock;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data, latched in the setup cycle and shown in the access phase
   always_comb
   begin
      rdata = '0;
      case (PADDR)
         OFS_RESULT_HIGH: rdata[BYTE_W-1:0] = {4'h0, result[RESULT_W-1:BYTE_W]};
         OFS_RESULT_LOW:  rdata[BYTE_W-1:0] = result[BYTE_W-1:0];
         OFS_CMP_HIGH:    rdata[BYTE_W-1:0] = cmp_high;
         OFS_CMP_LOW:     rdata[BYTE_W-1:0] = cmp_low;
         OFS_CONFIG:      rdata[BYTE_W-1:0] = cfg;
         OFS_PIN_SEL:     rdata[BYTE_W-1:0] = pin_sel;
         OFS_CMP_CTRL:
         begin
            rdata[CMP_EN_BIT] = cmp_en;
            rdata[CMP_GT_BIT] = cmp_gt;
         end
         OFS_STATUS:
         begin
            rdata[STAT_VAL_BIT]  = valid;
            rdata[STAT_LOCK_BIT] = lock;
         end
         default:         rdata = '0;
      endcase
      next_prdata = PRDATA;
      if (PSEL && !PENABLE)
         next_prdata = PWRITE ? '0 : rdata;
   end

   // Register read data
   always_ff @(posedge CLK_SYS or negedge RESET_N)
   begin
      if (!RESET_N)
         PRDATA <= '0;
      else
         PRDATA <= next_prdata;
   end

   ////////////////////////////////////////////////////////////////////////
   // Converter clock: source select then divide, as a one-cycle enable
   always_comb
   begin
      next_half = !half;
      case (cfg.input_clock)
         ADCR_SRC_BUS:      src_tick = 1'b1;
         ADCR_SRC_BUS_HALF: src_tick = half;
         ADCR_SRC_ALT:      src_tick = alt_tick;
         default:           src_tick = async_tick;
      endcase
      case (cfg.clock_divide)
         DIV_BY_1: div_max = 3'd0;
         2'b01:    div_max = 3'd1;
         2'b10:    div_max = 3'd3;
         default:  div_max = 3'd7;
      endcase
      next_div_cnt = div_cnt;
      next_clk_en  = 1'b0;
      if (src_tick)
      begin
         next_clk_en  = (div_cnt >= div_max);
         next_div_cnt = (div_cnt >= div_max) ? 3'd0 : 3'(div_cnt + 3'd1);
      end
   end

   // Register divider state
   always_ff @(posedge CLK_SYS or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         half        <= 1'b0;
         div_cnt     <= 3'd0;
         CONV_CLK_EN <= 1'b0;
      end
      else
      begin
         half        <= next_half;
         div_cnt     <= next_div_cnt;
         CONV_CLK_EN <= next_clk_en;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   a_high_nibble_12: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      (store && !mode_change && cfg.mode == ADCR_MODE_12) |=> result[11:8] == $past(CONV_RESULT[11:8]))
      else $error("high byte lost upper result bits");
   a_top_zero_mode: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      (cfg.mode == ADCR_MODE_10 |-> result[11:10] == 2'b00) and (cfg.mode == ADCR_MODE_8 |-> result[11:8] == 4'h0))
      else $error("unused result bits not zero");
   a_store_no_cmp: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      (done_ev && !lock && !hi_setup && !cmp_en && !mode_change) |=> valid && result == $past(res_m))
      else $error("completion not stored");
   a_hold_cmp_fail: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      (done_ev && cmp_en && !cond && !mode_change) |=> $stable(result))
      else $error("failed compare changed result");
   a_lock_set: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      (rd_en && PADDR == OFS_RESULT_HIGH && interlock_mode && !mode_change) |=> lock ##1 (lock || $past(rd_en)))
      else $error("high read did not lock");
   a_locked_discard: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      (lock && done_ev && !mode_change) |=> $stable(result) && $stable(valid))
      else $error("result changed while locked");
   a_no_lock_8: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      cfg.mode == ADCR_MODE_8 |-> !lock)
      else $error("interlock active in 8-bit mode");
   a_mode_invalid: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      mode_change |=> !valid && result == '0 && !lock)
      else $error("mode change kept result");
   a_low_byte_8: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      (store && !mode_change && cfg.mode == ADCR_MODE_8) |=> result[7:0] == $past(CONV_RESULT[7:0]))
      else $error("low byte wrong in 8-bit mode");
   a_cmp_high_12: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      (done_ev && cmp_en && !cmp_gt && cfg.mode == ADCR_MODE_12 && !mode_change &&
       CONV_RESULT[11:8] > cmp_high[3:0]) |=> $stable(result))
      else $error("12-bit compare ignored high bits");
   a_cmp_high_10: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      (done_ev && cmp_en && cmp_gt && cfg.mode == ADCR_MODE_10 && !mode_change &&
       CONV_RESULT[9:8] < cmp_high[1:0]) |=> $stable(result))
      else $error("10-bit compare ignored bits 9:8");
   a_cmp_low_8: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      (done_ev && !lock && !hi_setup && cmp_en && !cmp_gt && cfg.mode == ADCR_MODE_8 && !mode_change &&
       CONV_RESULT[7:0] < cmp_low) |=> valid && result[7:0] == $past(CONV_RESULT[7:0]))
      else $error("8-bit compare used high byte");
   a_cmp_equal_gt: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      (done_ev && !lock && !hi_setup && cmp_en && cmp_gt && res_m == cv && !mode_change) |=> valid)
      else $error("equal value not stored with greater select");
   a_cfg_fields: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      (wr_en && PADDR == OFS_CONFIG) |=> CONFIG.low_power == $past(PWDATA[7]) &&
      CONFIG.long_sample == $past(PWDATA[4]) && CONFIG.mode == $past(PWDATA[3:2]))
      else $error("configuration field mismatch");
   a_div_eight: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      (CONV_CLK_EN && cfg.input_clock == ADCR_SRC_BUS && cfg.clock_divide == DIV_BY_8 && !wr_en) ##1
      (!wr_en && !CONV_CLK_EN) [*7] |=> CONV_CLK_EN)
      else $error("divide by 8 period wrong");
   a_half_clock: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      (CONV_CLK_EN && cfg.input_clock == ADCR_SRC_BUS_HALF && cfg.clock_divide == DIV_BY_1 && !wr_en) ##1
      !wr_en |-> !CONV_CLK_EN ##1 CONV_CLK_EN)
      else $error("halved bus clock period wrong");
   a_pin_select: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      (wr_en && PADDR == OFS_PIN_SEL) |=> PIN_IO_DISABLE == $past(PWDATA[7:0]))
      else $error("pin select not applied");
   a_result_ro: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      (wr_en && (PADDR == OFS_RESULT_HIGH || PADDR == OFS_RESULT_LOW) && !done_ev) |=> $stable(result))
      else $error("write altered result");

endmodule

`default_nettype wire

/* File: test/adc_result_compare_config_regs_bench.sv */
// Purpose: Self-checking bench for the result, compare and configuration registers
// Assumes: Zero wait state APB slave, results land within 10 clocks
// Notes:   Reads queue their expected byte; a monitor pops and compares
`default_nettype none
module adc_result_compare_config_regs_bench
   import adcr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, go = 0, err = 0, rdy, slv, done, clken;
   logic [7:0]  pa = 0, cw, pins;
   logic [31:0] pwd = 0, prd, n;
   logic [11:0] val = 0, res;
   logic [4:0]  tk = 0;                        // Slow alternate and async clock levels
   adcr_cfg_t   cfg;
   logic [7:0]  exp_q[$];                      // Expected read bytes, oldest first
   int          error_cnt = 0, cmp_count = 0;
   logic [7:0]  cws[7] = '{8'h00, 8'h20, 8'h40, 8'h60, 8'h01, 8'h02, 8'h03};
   int          cds[7] = '{96, 48, 24, 12, 48, 6, 3};
   always #25 clk = ~clk;
   always @(posedge clk) tk <= tk + 5'h01;
   adcr_result_regs DUT (.CLK_SYS(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
      .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(rdy), .PSLVERR(slv), .CONV_DONE(done),
      .CONV_RESULT(res), .ALT_CLK(tk[3]), .ASYNC_CLK(tk[4]), .CONFIG(cfg), .CONV_CLK_EN(clken),
      .PIN_IO_DISABLE(pins));
   adcr_core_model CORE (.CLK_SYS(clk), .GO(go), .VAL(val), .CONV_DONE(done), .CONV_RESULT(res));
   // Compare and count
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] want);
      cmp_count++;
      if (seen !== want)
      begin
         $display("BAD %s expected %h seen %h", nm, want, seen);
         error_cnt++;
      end
   endtask
   // One APB transfer, held until PREADY at the access edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      psel <= 1'b1; pwr <= w; pa <= a; pwd <= {24'h0, d};
      @(posedge clk) pen <= 1'b1;
      do @(posedge clk); while (rdy !== 1'b1);
      psel <= 1'b0; pen <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 8'h00);
   endtask
   // One completed conversion from the core
   task automatic conv(input logic [11:0] v);
      go <= 1'b1; val <= v;
      @(posedge clk) go <= 1'b0;
      repeat (10) @(posedge clk);
   endtask
   // Access phase monitor, sampled at the completing rising edge
   always @(posedge clk)
      if (psel && pen && rdy)
      begin
         err = slv;
         if (!pwr)
            chk("read data", prd, {24'h0, exp_q.pop_front()});
      end
   task automatic complete_run;
      $display("mismatches %0d in %0d checks", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial
   begin
      repeat (4000) @(posedge clk);
      error_cnt++;
      complete_run;
   end
   initial
   begin
      void'($urandom(89));
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(OFS_CONFIG, CFG_RESET);
      rd(OFS_PIN_SEL, PIN_RESET);
      n = $urandom;
      wr(OFS_PIN_SEL, n[7:0]);
      chk("pins", 32'(pins), 32'(n[7:0]));
      cw = (8'($urandom) & 8'hF3) | 8'h04;
      wr(OFS_CONFIG, cw);
      rd(OFS_CONFIG, cw);
      chk("config", 32'(cfg), 32'(cw));
      conv(12'hABC);
      rd(OFS_RESULT_HIGH, 8'h0A);
      conv(12'h123);
      rd(OFS_RESULT_LOW, 8'hBC);
      conv(12'h456);
      rd(OFS_RESULT_HIGH, 8'h04);
      rd(OFS_RESULT_LOW, 8'h56);
      wr(OFS_RESULT_LOW, 8'hFF);
      wr(OFS_CMP_HIGH, 8'h01);
      wr(OFS_CMP_LOW, 8'h00);
      wr(OFS_CMP_CTRL, 8'h03);
      conv(12'h0FF);
      rd(OFS_RESULT_LOW, 8'h56);
      conv(12'h100);
      rd(OFS_RESULT_HIGH, 8'h01);
      rd(OFS_RESULT_LOW, 8'h00);
      wr(OFS_CMP_CTRL, 8'h01);
      conv(12'h0FF);
      rd(OFS_RESULT_LOW, 8'hFF);
      wr(OFS_CMP_CTRL, 8'h00);
      wr(OFS_CONFIG, 8'h08);
      rd(OFS_RESULT_LOW, 8'h00);
      conv(12'hFFF);
      rd(OFS_RESULT_HIGH, 8'h03);
      wr(OFS_CONFIG, 8'h00);
      wr(OFS_CMP_CTRL, 8'h03);
      wr(OFS_CMP_LOW, 8'h80);
      conv(12'h190);
      rd(OFS_RESULT_LOW, 8'h90);
      rd(OFS_RESULT_HIGH, 8'h00);
      conv(12'h0C7);
      rd(OFS_RESULT_LOW, 8'hC7);
      conv(12'h07F);
      rd(OFS_RESULT_LOW, 8'hC7);
      rd(8'h20, 8'h00);
      chk("slave error", 32'(err), 32'h1);
      foreach (cws[i])
      begin
         wr(OFS_CONFIG, cws[i]);
         n = 0;
         repeat (40) @(posedge clk);
         repeat (96) @(negedge clk) n += 32'(clken);
         chk("clock enables", n, 32'(cds[i]));
      end
      complete_run;
   end
endmodule
`default_nettype wire

/* File: test/adcr_core_model.sv */
// Purpose: Stand-in for the analog conversion core
// Assumes: GO pulses at least 8 clocks apart
// Notes:   Result scrambles each cycle once its hold runs out
`default_nettype none
module adcr_core_model
(
   input  wire logic        CLK_SYS,
   input  wire logic        GO,
   input  wire logic [11:0] VAL,
   output logic             CONV_DONE,
   output logic [11:0]      CONV_RESULT
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] hold = 3'h0;                 // Cycles of result hold left
   initial CONV_DONE = 1'b0;
   initial CONV_RESULT = 12'h000;
   // One toggle per completion; old result must not linger
   always @(posedge CLK_SYS)
   begin
      if (GO)
      begin
         CONV_DONE   <= ~CONV_DONE;
         CONV_RESULT <= VAL;
         hold        <= 3'h6;
      end
      else if (hold != 3'h0)
         hold <= hold - 3'h1;
      else
         CONV_RESULT <= CONV_RESULT + 12'h3A7;
   end
endmodule
`default_nettype wire
